// file: rtl/acsltr_pkg.sv
package acsltr_pkg;

  localparam int ADDR_W = 12;

  localparam logic [11:0] PWR_BUDGET_HDR_OFF = 12'h20C;
  localparam logic [11:0] ACCESS_CTRL_CAP_HEADER_OFF = 12'h220;
  localparam logic [11:0] ACCESS_CTRL_CAPABILITY_CONTROL_OFF = 12'h224;
  localparam logic [11:0] EGRESS_BLOCK_VECTOR_OFF = 12'h228;
  localparam logic [11:0] LATENCY_REPORT_CAP_HEADER_OFF = 12'h230;
  localparam logic [11:0] MAX_SNOOP_LATENCY_OFF = 12'h234;

  localparam logic [15:0] PWR_BUDGET_CAP_ID = 16'h0004;
  localparam logic [15:0] ACCESS_CTRL_CAP_ID = 16'h000D;
  localparam logic [15:0] LATENCY_REPORT_CAP_ID = 16'h0018;
  localparam logic [3:0] CAP_VERSION = 4'h1;
  localparam logic [11:0] NEXT_CAP_END = 12'h000;
  localparam logic [11:0] NEXT_CAP_UPSTREAM = 12'h230;
  localparam logic [11:0] NEXT_CAP_DOWNSTREAM = 12'h220;

  localparam logic [6:0] ACS_FEATURES = 7'h7F;
  localparam logic [7:0] EGRESS_VECTOR_SIZE = 8'h08;
  localparam int ACS_ENABLE_LSB = 16;
  localparam int ACS_SIZE_LSB = 8;

  localparam logic [31:0] CTL_WMASK = 32'h007F0000;
  localparam logic [31:0] EGRESS_WMASK = 32'h000000FF;
  localparam logic [31:0] LAT_WMASK = 32'h1FFF1FFF;
  localparam logic [31:0] CTL_RESET = 32'h00000000;
  localparam logic [31:0] EGRESS_RESET = 32'h00000000;
  localparam logic [31:0] LAT_RESET = 32'h00000000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {
    ACSLTR_SEL_NONE = 3'b000,
    ACSLTR_SEL_PWR_HDR = 3'b001,
    ACSLTR_SEL_ACS_HDR = 3'b010,
    ACSLTR_SEL_ACS_CTL = 3'b011,
    ACSLTR_SEL_EGRESS = 3'b100,
    ACSLTR_SEL_LTR_HDR = 3'b101,
    ACSLTR_SEL_LAT = 3'b110
  } acsltr_sel_t;

endpackage : acsltr_pkg

// file: rtl/acsltr_regs.sv
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
// Contract
// - Downstream header reads capability ID 000Dh.
// - Both headers report version 1h.
// - Both headers end the chain with 000h.
// - Capability bits 0..6 read as one.
// - Egress vector size field reads 08h.
// - Enable bits 16..22 writable, reset zero.
// - Egress vector bits 7:0 writable, reset zero.
// - Access-control registers exist on downstream ports only.
// - Upstream header reads capability ID 0018h.
// - Latency registers exist on upstream port only.
// - Snoop latency value 9:0 writable, reset zero.
// - Snoop latency scale 12:10 writable, reset zero.
// - Power budgeting header points to 230h/220h.
// - No-snoop latency value 25:16 writable, reset zero.
module acsltr_regs (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic PORT_IS_UPSTREAM,
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [6:0] ACS_FEATURE_ENABLE,
  output logic [7:0] EGRESS_BLOCK,
  output logic [9:0] MAX_SNOOP_VALUE,
  output logic [2:0] MAX_SNOOP_SCALE,
  output logic [9:0] MAX_NO_SNOOP_VALUE,
  output logic [2:0] MAX_NO_SNOOP_SCALE
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);

  ////////////////////////////////////////////////////////////////////////////
  // Decode shared by the read and the write paths.

  // A register that does not exist on this port type decodes as unmapped.
  function automatic acsltr_pkg::acsltr_sel_t decode(
    input logic [11:0] addr,
    input logic up
  );
    acsltr_pkg::acsltr_sel_t sel;
    sel = acsltr_pkg::ACSLTR_SEL_NONE;
    case ({addr[11:2], 2'b00})
      acsltr_pkg::PWR_BUDGET_HDR_OFF: sel = acsltr_pkg::ACSLTR_SEL_PWR_HDR;
      acsltr_pkg::ACCESS_CTRL_CAP_HEADER_OFF: begin
        if (!up) sel = acsltr_pkg::ACSLTR_SEL_ACS_HDR;
      end
      acsltr_pkg::ACCESS_CTRL_CAPABILITY_CONTROL_OFF: begin
        if (!up) sel = acsltr_pkg::ACSLTR_SEL_ACS_CTL;
      end
      acsltr_pkg::EGRESS_BLOCK_VECTOR_OFF: begin
        if (!up) sel = acsltr_pkg::ACSLTR_SEL_EGRESS;
      end
      acsltr_pkg::LATENCY_REPORT_CAP_HEADER_OFF: begin
        if (up) sel = acsltr_pkg::ACSLTR_SEL_LTR_HDR;
      end
      acsltr_pkg::MAX_SNOOP_LATENCY_OFF: begin
        if (up) sel = acsltr_pkg::ACSLTR_SEL_LAT;
      end
      default: sel = acsltr_pkg::ACSLTR_SEL_NONE;
    endcase
    return sel;
  endfunction : decode

  // Only writable positions change; reserved bits keep their zero.
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0] strb,
    input logic [31:0] wmask
  );
    logic [31:0] bmask;
    bmask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~(bmask & wmask)) | (data & bmask & wmask);
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // Write channel.

  logic aw_held;
  logic w_held;
  logic [11:0] awaddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic bvalid;
  logic [1:0] bresp;
  logic [31:0] ctl;
  logic [31:0] egress;
  logic [31:0] lat;
  logic next_aw_held;
  logic next_w_held;
  logic [11:0] next_awaddr;
  logic [31:0] next_wdata;
  logic [3:0] next_wstrb;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic [31:0] next_ctl;
  logic [31:0] next_egress;
  logic [31:0] next_lat;
  logic aw_take;
  logic w_take;
  logic do_write;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  acsltr_pkg::acsltr_sel_t wr_sel;

  // Address and data are each taken on their own; the write happens in the
  // cycle both are present, so either order costs no extra cycle.
  assign S_AXI_AWREADY = !aw_held && !bvalid;
  assign S_AXI_WREADY = !w_held && !bvalid;
  assign aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
  assign w_take = S_AXI_WVALID && S_AXI_WREADY;
  assign wr_addr = aw_held ? awaddr : S_AXI_AWADDR;
  assign wr_data = w_held ? wdata : S_AXI_WDATA;
  assign wr_strb = w_held ? wstrb : S_AXI_WSTRB;
  assign do_write = (aw_held || aw_take) && (w_held || w_take);
  assign wr_sel = decode(wr_addr, PORT_IS_UPSTREAM);

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_awaddr = awaddr;
    next_wdata = wdata;
    next_wstrb = wstrb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_ctl = ctl;
    next_egress = egress;
    next_lat = lat;
    if (aw_take) begin
      next_aw_held = 1'b1;
      next_awaddr = S_AXI_AWADDR;
    end
    if (w_take) begin
      next_w_held = 1'b1;
      next_wdata = S_AXI_WDATA;
      next_wstrb = S_AXI_WSTRB;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = acsltr_pkg::RESP_OKAY;
      case (wr_sel)
        acsltr_pkg::ACSLTR_SEL_ACS_CTL:
          next_ctl = merge(ctl, wr_data, wr_strb,
                           acsltr_pkg::CTL_WMASK);
        acsltr_pkg::ACSLTR_SEL_EGRESS:
          next_egress = merge(egress, wr_data, wr_strb,
                              acsltr_pkg::EGRESS_WMASK);
        acsltr_pkg::ACSLTR_SEL_LAT:
          next_lat = merge(lat, wr_data, wr_strb,
                           acsltr_pkg::LAT_WMASK);
        acsltr_pkg::ACSLTR_SEL_NONE:
          next_bresp = acsltr_pkg::RESP_DECERR;
        default: next_bresp = acsltr_pkg::RESP_OKAY;
      endcase
    end else if (bvalid && S_AXI_BREADY) begin
      next_bvalid = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr <= 12'h000;
      wdata <= 32'h00000000;
      wstrb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= acsltr_pkg::RESP_OKAY;
      ctl <= acsltr_pkg::CTL_RESET;
      egress <= acsltr_pkg::EGRESS_RESET;
      lat <= acsltr_pkg::LAT_RESET;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      awaddr <= next_awaddr;
      wdata <= next_wdata;
      wstrb <= next_wstrb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      ctl <= next_ctl;
      egress <= next_egress;
      lat <= next_lat;
    end
  end

  assign S_AXI_BVALID = bvalid;
  assign S_AXI_BRESP = bresp;

  ////////////////////////////////////////////////////////////////////////////
  // Read channel.

  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic [31:0] read_word;
  acsltr_pkg::acsltr_sel_t rd_sel;

  assign S_AXI_ARREADY = !rvalid;
  assign rd_sel = decode(S_AXI_ARADDR, PORT_IS_UPSTREAM);

  always_comb begin
    read_word = 32'h00000000;
    case (rd_sel)
      acsltr_pkg::ACSLTR_SEL_PWR_HDR:
        read_word = {PORT_IS_UPSTREAM ? acsltr_pkg::NEXT_CAP_UPSTREAM
                                      : acsltr_pkg::NEXT_CAP_DOWNSTREAM,
                     acsltr_pkg::CAP_VERSION,
                     acsltr_pkg::PWR_BUDGET_CAP_ID};
      acsltr_pkg::ACSLTR_SEL_ACS_HDR:
        read_word = {acsltr_pkg::NEXT_CAP_END, acsltr_pkg::CAP_VERSION,
                     acsltr_pkg::ACCESS_CTRL_CAP_ID};
      acsltr_pkg::ACSLTR_SEL_ACS_CTL: begin
        read_word = ctl;
        read_word[6:0] = acsltr_pkg::ACS_FEATURES;
        read_word[acsltr_pkg::ACS_SIZE_LSB +: 8] =
          acsltr_pkg::EGRESS_VECTOR_SIZE;
      end
      acsltr_pkg::ACSLTR_SEL_EGRESS: read_word = egress;
      acsltr_pkg::ACSLTR_SEL_LTR_HDR:
        read_word = {acsltr_pkg::NEXT_CAP_END, acsltr_pkg::CAP_VERSION,
                     acsltr_pkg::LATENCY_REPORT_CAP_ID};
      acsltr_pkg::ACSLTR_SEL_LAT: read_word = lat;
      default: read_word = 32'h00000000;
    endcase
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (S_AXI_ARVALID && !rvalid) begin
      next_rvalid = 1'b1;
      next_rdata = read_word;
      next_rresp = (rd_sel == acsltr_pkg::ACSLTR_SEL_NONE)
                   ? acsltr_pkg::RESP_DECERR : acsltr_pkg::RESP_OKAY;
    end else if (rvalid && S_AXI_RREADY) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= acsltr_pkg::RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  assign S_AXI_RVALID = rvalid;
  assign S_AXI_RDATA = rdata;
  assign S_AXI_RRESP = rresp;

  // Enables and vector drive the forwarding logic outside this bank.
  assign ACS_FEATURE_ENABLE = ctl[acsltr_pkg::ACS_ENABLE_LSB +: 7];
  assign EGRESS_BLOCK = egress[7:0];
  assign MAX_SNOOP_VALUE = lat[9:0];
  assign MAX_SNOOP_SCALE = lat[12:10];
  assign MAX_NO_SNOOP_VALUE = lat[25:16];
  assign MAX_NO_SNOOP_SCALE = lat[28:26];

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_acs_hdr_read: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY && !PORT_IS_UPSTREAM &&
    S_AXI_ARADDR == 12'h220 |=> S_AXI_RVALID && S_AXI_RDATA == 32'h0001000D)
    else $error("access-control header read wrong");
  a_ltr_hdr_read: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY && PORT_IS_UPSTREAM &&
    S_AXI_ARADDR == 12'h230 |=> S_AXI_RDATA == 32'h00010018)
    else $error("latency header read wrong");
  a_hdr_version: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY &&
    (PORT_IS_UPSTREAM ? S_AXI_ARADDR == 12'h230 : S_AXI_ARADDR == 12'h220)
    |=> S_AXI_RRESP == 2'h0 && S_AXI_RDATA[19:16] == 4'h1)
    else $error("header version wrong");
  a_chain_end: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY &&
    (S_AXI_ARADDR == 12'h220 || S_AXI_ARADDR == 12'h230) |=>
    S_AXI_RDATA[31:20] == 12'h000)
    else $error("chain pointer not zero");
  a_cap_fixed: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY && !PORT_IS_UPSTREAM &&
    S_AXI_ARADDR == 12'h224 |=> S_AXI_RDATA[15:0] == 16'h087F &&
    S_AXI_RDATA[31:23] == 9'h000)
    else $error("capability fixed fields wrong");
  a_enable_write: assert property (
    do_write && wr_sel == acsltr_pkg::ACSLTR_SEL_ACS_CTL && wr_strb[2] |=>
    ACS_FEATURE_ENABLE == $past(wr_data[22:16]))
    else $error("enable bits not written");
  a_egress_write: assert property (
    do_write && wr_sel == acsltr_pkg::ACSLTR_SEL_EGRESS && wr_strb[0] |=>
    EGRESS_BLOCK == $past(wr_data[7:0]) && egress[31:8] == 24'h000000)
    else $error("egress vector write wrong");
  a_port_absent: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY && PORT_IS_UPSTREAM &&
    S_AXI_ARADDR == 12'h228 |=> S_AXI_RRESP == 2'h3 &&
    S_AXI_RDATA == 32'h00000000)
    else $error("downstream register visible upstream");
  a_lat_absent: assert property (
    do_write && !PORT_IS_UPSTREAM && wr_addr == 12'h234 |=>
    $stable(lat) && S_AXI_BRESP == 2'h3)
    else $error("latency register written downstream");
  a_lat_write: assert property (
    do_write && wr_sel == acsltr_pkg::ACSLTR_SEL_LAT && wr_strb == 4'hF |=>
    MAX_SNOOP_VALUE == $past(wr_data[9:0]) &&
    MAX_SNOOP_SCALE == $past(wr_data[12:10]) &&
    MAX_NO_SNOOP_VALUE == $past(wr_data[25:16]) && lat[15:13] == 3'h0)
    else $error("latency write wrong");
  a_pwr_pointer: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 12'h20C |=>
    S_AXI_RDATA[31:20] == ($past(PORT_IS_UPSTREAM) ? 12'h230 : 12'h220))
    else $error("power budgeting pointer wrong");

endmodule : acsltr_regs

// file: verif/acsltr_regs_tb.sv
`timescale 1ns/1ns
module acsltr_regs_tb;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic up_port = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [6:0] feat_en;
  logic [7:0] egress;
  logic [9:0] snoop_val, nosnoop_val;
  logic [2:0] snoop_scale, nosnoop_scale;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;

  acsltr_regs u_acsltr_regs (
    .CLK_SYS(clk_sys), .RESET_N(reset_n), .PORT_IS_UPSTREAM(up_port),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .ACS_FEATURE_ENABLE(feat_en),
    .EGRESS_BLOCK(egress), .MAX_SNOOP_VALUE(snoop_val),
    .MAX_SNOOP_SCALE(snoop_scale), .MAX_NO_SNOOP_VALUE(nosnoop_val),
    .MAX_NO_SNOOP_SCALE(nosnoop_scale)
  );

  always #20 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("Compared %0d values, %0d mismatches", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  // A hang in any handshake wait ends here rather than running forever.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      conclude();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic do_reset(input logic up);
    reset_n <= 1'b0;
    up_port <= up;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////
  // Handshakes are judged at the rising edge itself, where the design
  // samples them. Each call first lets an edge pass, so that a ready the
  // previous call has just lowered is never raised in the same time step.
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [1:0] r);
    logic b_hit;
    b_hit = 1'b0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_hit) begin
      @(posedge clk_sys);
      if (bvalid) begin
        b_hit = 1'b1;
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, r});
      end
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    logic r_hit;
    r_hit = 1'b0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_hit) begin
      @(posedge clk_sys);
      if (rvalid) begin
        r_hit = 1'b1;
        rready <= 1'b0;
        check(rdata, d);
        check({30'h0, rresp}, {30'h0, r});
      end
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
  endtask : axi_rd

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_down_reset;
    do_reset(1'b0);
    check({17'h0, feat_en, egress}, 32'h0);
    axi_rd(12'h20C, 32'h22010004, 2'h0);
    axi_rd(12'h220, 32'h0001000D, 2'h0);
    axi_rd(12'h224, 32'h0000087F, 2'h0);
    axi_rd(12'h228, 32'h00000000, 2'h0);
    axi_rd(12'h230, 32'h00000000, 2'h3);
    axi_rd(12'h234, 32'h00000000, 2'h3);
    axi_rd(12'h300, 32'h00000000, 2'h3);
  endtask : t_down_reset

  task automatic t_down_write;
    axi_wr(12'h224, 32'hFFFFFFFF, 4'hF, 2'h0);
    axi_rd(12'h224, 32'h007F087F, 2'h0);
    check({25'h0, feat_en}, 32'h0000007F);
    axi_wr(12'h224, 32'h00000000, 4'hB, 2'h0);
    axi_rd(12'h224, 32'h007F087F, 2'h0);
    axi_wr(12'h224, 32'h00000000, 4'h4, 2'h0);
    axi_rd(12'h224, 32'h0000087F, 2'h0);
    axi_wr(12'h228, 32'hFFFFFFFF, 4'hF, 2'h0);
    axi_rd(12'h228, 32'h000000FF, 2'h0);
    check({24'h0, egress}, 32'h000000FF);
    axi_wr(12'h220, 32'h00000000, 4'hF, 2'h0);
    axi_rd(12'h220, 32'h0001000D, 2'h0);
    axi_wr(12'h234, 32'hFFFFFFFF, 4'hF, 2'h3);
  endtask : t_down_write

  task automatic t_upstream;
    do_reset(1'b1);
    check({24'h0, egress}, 32'h0);
    axi_rd(12'h20C, 32'h23010004, 2'h0);
    axi_rd(12'h230, 32'h00010018, 2'h0);
    axi_rd(12'h234, 32'h00000000, 2'h0);
    axi_rd(12'h220, 32'h00000000, 2'h3);
    axi_rd(12'h224, 32'h00000000, 2'h3);
    axi_rd(12'h228, 32'h00000000, 2'h3);
    axi_wr(12'h224, 32'hFFFFFFFF, 4'hF, 2'h3);
    axi_wr(12'h234, 32'hFFFFFFFF, 4'hF, 2'h0);
    axi_rd(12'h234, 32'h1FFF1FFF, 2'h0);
    check({6'h0, nosnoop_scale, nosnoop_val, snoop_scale, snoop_val},
          32'h03FFFFFF);
    axi_wr(12'h234, 32'h00000000, 4'h1, 2'h0);
    axi_rd(12'h234, 32'h1FFF1F00, 2'h0);
  endtask : t_upstream

  initial begin
    t_down_reset();
    t_down_write();
    t_upstream();
    conclude();
  end
endmodule : acsltr_regs_tb
